/* core/acr_pkg.sv */
// Constants, codes and types shared by the conversion-data readout block.
// Assumes the sample clock i_clk and a host-driven serial clock on the link side.
package acr_pkg;

    localparam int DATA_W = 16;
    localparam int RAW_W = 19;
    localparam int WORD_W = 32;
    localparam int CNT_W = 6;
    localparam int PROD_W = 38;

    // Output code limits, bipolar and unipolar.
    localparam logic signed [PROD_W-1:0] BI_POS_FS = 38'sh0_0000_7fff;
    localparam logic signed [PROD_W-1:0] BI_NEG_FS = -38'sh0_0000_8000;
    localparam logic signed [PROD_W-1:0] UNI_FS = 38'sh0_0000_ffff;
    localparam logic [DATA_W-1:0] CODE_BI_MAX = 16'h7fff;
    localparam logic [DATA_W-1:0] CODE_BI_MIN = 16'h8000;
    localparam logic [DATA_W-1:0] CODE_UNI_MAX = 16'hffff;
    localparam logic [DATA_W-1:0] CODE_UNI_MIN = 16'h0000;

    // Extended range gain of 0.8 as a 16-bit fraction with round to nearest.
    localparam logic signed [PROD_W-1:0] EXT_GAIN = 38'sh0_0000_cccd;
    localparam logic signed [PROD_W-1:0] EXT_ROUND = 38'sh0_0000_8000;
    localparam int EXT_SHIFT = 16;

    // Check code over output bytes.
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'hff;

    // Pad byte after a register readback byte and at the end of short frames.
    localparam logic [7:0] PAD_BYTE = 8'h00;

    // Cycle counts on i_clk.
    localparam logic [1:0] STBY_HIGH_CYC = 2'h3;
    localparam logic [1:0] RDY_PULSE_CYC = 2'h1;

    // Frame geometry in serial clocks.
    localparam logic [CNT_W-1:0] BYTE_BITS = 6'h08;
    localparam logic [CNT_W-1:0] DATA_FIELD_BITS = 6'h10;

    // Reset values.
    localparam logic [DATA_W-1:0] CODE_RST = 16'h0000;
    localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        ACR_RDY_HIGH = 3'b001,
        ACR_RDY_LOW = 3'b010,
        ACR_RDY_PULSE = 3'b100
    } acr_rdy_state_t;

endpackage : acr_pkg

/* core/acr_sync2.sv */
// Two flip-flop level synchroniser into the i_clk domain.
// Assumes the input is a level that stays put for several destination cycles.
`timescale 1ns/10ps
module acr_sync2 (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_d,
    output logic o_q
);
    logic meta_r;
    logic hold_r;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            meta_r <= 1'b0;
            hold_r <= 1'b0;
        end else begin
            meta_r <= i_d;
            hold_r <= meta_r;
        end
    end

    assign o_q = hold_r;

endmodule : acr_sync2

/* core/acr_crc8.sv */
// Combinational check code over up to three output bytes, first byte optional.
// Assumes the caller registers the result.
`timescale 1ns/10ps
module acr_crc8 (
    input wire logic [23:0] i_bytes,
    input wire logic i_use_first,
    output logic [7:0] o_crc
);
    import acr_pkg::*;

    always_comb begin
        logic [7:0] crc;
        logic fb;
        crc = CRC_INIT;
        fb = 1'b0;
        for (int i = 0; i < 24; i++) begin
            if (i >= 8 || i_use_first) begin
                fb = crc[7] ^ i_bytes[23-i];
                crc = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
            end
        end
        o_crc = crc;
    end

endmodule : acr_crc8

/* core/acr_readout.sv */
// Conversion-data readout: result coding, data-ready pin, status header and serial frame.
// Assumes a host serial master that shifts on the serial clock while chip select is low,
// sampling on falling edges; the serial clock only runs inside frames.
//
// What this block does
// - Host reads results by chip select and clocks alone; register readback replaces data.
// - Output check code covers every earlier output byte, header included.
// - Long format, non one-shot: ready high and header bit cleared at 16th fall.
// - Shift started before the ready edge gets old data, after it new data.
// - Bipolar results are 16-bit two's complement, sign first.
// - Unipolar results are straight binary, zero or below maps to zero.
// - Codes saturate at full scale instead of wrapping.
// - Extended range scales nominal full scale to reduced codes.
// - Ready pin goes high on start or resync, low on new result.
// - Non one-shot modes end ready low at eighth data clock; one-shot keeps it.
// - With standby after conversion, ready returns high three clocks after falling.
// - Unread result: ready pulses high briefly before the next falling edge.
// - Ready pin keeps working whatever chip select does.
// - Dual-function pin mirrors ready until first serial rise, then shifts data.
// - After the last bit the dual-function pin mirrors ready again.
// - Pin function select low: pin holds its last level until shifting begins.
// - Header bit 0 is one for unread data, cleared by a read until next result.
// - Header enable prefixes a status byte equal to the status register.
// - Data field is two bytes; each disabled header or check byte shortens frame.
`timescale 1ns/10ps
module acr_readout (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_conv_start,
    input wire logic i_result_valid,
    input wire logic signed [acr_pkg::RAW_W-1:0] i_result_raw,
    input wire logic i_unipolar,
    input wire logic i_ext_range,
    input wire logic i_one_shot,
    input wire logic i_standby_after_conversion,
    input wire logic i_out_pin_function_sel,
    input wire logic i_status_hdr_en,
    input wire logic i_crc_en,
    input wire logic [7:1] i_status_bits,
    input wire logic i_reg_read_pending,
    input wire logic [7:0] i_reg_read_data,
    output logic o_result_ready_n,
    output logic o_dual_function_out_pin,
    output logic o_dual_function_out_pin_oe,
    output logic [7:0] o_status_byte,
    output logic o_read_seen
);
    import acr_pkg::*;

    // Clip and scale a filter result into the output code.
    function automatic logic [DATA_W-1:0] code_of(
        input logic signed [RAW_W-1:0] raw,
        input logic uni,
        input logic ext
    );
        logic signed [PROD_W-1:0] wide;
        logic signed [PROD_W-1:0] val;
        logic [DATA_W-1:0] code;
        wide = PROD_W'(raw);
        val = ext ? ((wide * EXT_GAIN + EXT_ROUND) >>> EXT_SHIFT) : wide;
        if (uni) begin
            if (val <= 0) begin
                code = CODE_UNI_MIN;
            end else if (val > UNI_FS) begin
                code = CODE_UNI_MAX;
            end else begin
                code = val[DATA_W-1:0];
            end
        end else begin
            if (val > BI_POS_FS) begin
                code = CODE_BI_MAX;
            end else if (val < BI_NEG_FS) begin
                code = CODE_BI_MIN;
            end else begin
                code = val[DATA_W-1:0];
            end
        end
        return code;
    endfunction : code_of

    // Serial clock count at which the last bit of the most significant data byte falls.
    function automatic logic [CNT_W-1:0] msb_last_of(input logic hdr);
        return hdr ? (BYTE_BITS + BYTE_BITS) : BYTE_BITS;
    endfunction : msb_last_of

    // ---- Sample clock domain ----

    acr_rdy_state_t rdy_state_r;
    logic [DATA_W-1:0] code_r;
    logic fresh_r;
    logic [1:0] rdy_cnt_r;
    logic busy_s;
    logic read_tgl_s;
    logic read_tgl_d_r;
    logic read_evt;
    logic [WORD_W-1:0] pub_word_r;
    logic pub_hdr_r;
    logic pub_crc_r;
    logic [7:0] status_now;
    logic [DATA_W-1:0] field_now;
    logic [7:0] crc_now;
    logic late_r;
    logic read_hit;

    // ---- Serial clock domain ----

    logic started_r;
    logic done_r;
    logic [CNT_W-1:0] fall_cnt_r;
    logic [WORD_W-1:0] shift_r;
    logic read_tgl_r;
    logic [CNT_W-1:0] last_bit_cnt;

    // The read toggle crosses as a level and is turned into a one-cycle event here.
    acr_sync2 u_read_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_d(read_tgl_r),
        .o_q(read_tgl_s)
    );

    // Tells the sample domain that a shift is under way, so the frame word stays frozen.
    acr_sync2 u_busy_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_d(started_r),
        .o_q(busy_s)
    );

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            read_tgl_d_r <= 1'b0;
        end else begin
            read_tgl_d_r <= read_tgl_s;
        end
    end

    assign read_evt = read_tgl_s ^ read_tgl_d_r;
    assign o_read_seen = read_evt;

    // A result that lands after the frame word froze is not the one being read out, so that
    // read must neither clear the unread flag nor raise the ready pin.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            late_r <= 1'b0;
        end else if (!busy_s) begin
            late_r <= 1'b0;
        end else if (i_result_valid) begin
            late_r <= 1'b1;
        end
    end

    assign read_hit = read_evt && !late_r;

    // Latest result code.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            code_r <= CODE_RST;
        end else if (i_result_valid) begin
            code_r <= code_of(i_result_raw, i_unipolar, i_ext_range);
        end
    end

    // Data-ready state. Start outranks a new result, which outranks a read and standby.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdy_state_r <= ACR_RDY_HIGH;
            rdy_cnt_r <= 2'h0;
        end else if (i_conv_start) begin
            rdy_state_r <= ACR_RDY_HIGH;
            rdy_cnt_r <= 2'h0;
        end else if (i_result_valid) begin
            if (rdy_state_r == ACR_RDY_LOW) begin
                rdy_state_r <= ACR_RDY_PULSE;
                rdy_cnt_r <= RDY_PULSE_CYC;
            end else begin
                rdy_state_r <= ACR_RDY_LOW;
                rdy_cnt_r <= STBY_HIGH_CYC;
            end
        end else begin
            unique case (rdy_state_r)
                ACR_RDY_HIGH: begin
                    rdy_cnt_r <= 2'h0;
                end
                ACR_RDY_PULSE: begin
                    if (rdy_cnt_r == 2'h1) begin
                        rdy_state_r <= ACR_RDY_LOW;
                        rdy_cnt_r <= STBY_HIGH_CYC;
                    end else begin
                        rdy_cnt_r <= rdy_cnt_r - 2'h1;
                    end
                end
                ACR_RDY_LOW: begin
                    // Read ends low, not in one-shot.
                    if (read_hit && !i_one_shot) begin
                        rdy_state_r <= ACR_RDY_HIGH;
                    end else if (i_standby_after_conversion && rdy_cnt_r == 2'h1) begin
                        rdy_state_r <= ACR_RDY_HIGH;
                    end
                    if (rdy_cnt_r != 2'h0) begin
                        rdy_cnt_r <= rdy_cnt_r - 2'h1;
                    end
                end
                default: begin
                    rdy_state_r <= ACR_RDY_HIGH;
                    rdy_cnt_r <= 2'h0;
                end
            endcase
        end
    end

    // Pin driven from state only, independent of chip select.
    assign o_result_ready_n = (rdy_state_r != ACR_RDY_LOW);

    // Unread-data flag; a result arriving with a read in the same cycle keeps it set.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            fresh_r <= 1'b0;
        end else if (i_result_valid) begin
            fresh_r <= 1'b1;
        end else if (read_hit) begin
            fresh_r <= 1'b0;
        end
    end

    assign status_now = {i_status_bits, fresh_r};
    assign o_status_byte = status_now;

    assign field_now = i_reg_read_pending ? {i_reg_read_data, PAD_BYTE} : code_r;

    acr_crc8 u_crc (
        .i_bytes({status_now, field_now}),
        .i_use_first(i_status_hdr_en),
        .o_crc(crc_now)
    );

    // The frame word is only refreshed while no shift is running, so a frame that began
    // before a new result keeps the old one; the synchroniser delay is the uncertainty window.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pub_word_r <= WORD_RST;
            pub_hdr_r <= 1'b0;
            pub_crc_r <= 1'b0;
        end else if (!busy_s) begin
            pub_hdr_r <= i_status_hdr_en;
            pub_crc_r <= i_crc_en;
            if (i_status_hdr_en) begin
                pub_word_r <= {status_now, field_now, crc_now};
            end else begin
                pub_word_r <= {field_now, crc_now, PAD_BYTE};
            end
        end
    end

    // ---- Serial link ----

    assign last_bit_cnt = DATA_FIELD_BITS
        + (pub_hdr_r ? BYTE_BITS : 6'h00)
        + (pub_crc_r ? BYTE_BITS : 6'h00);

    // Frame state is cleared by chip select going high, since the serial clock stops then.
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            started_r <= 1'b0;
        end else begin
            started_r <= 1'b1;
        end
    end

    // Load on first rise, then shift.
    always_ff @(posedge i_sclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            shift_r <= WORD_RST;
        end else if (!started_r) begin
            shift_r <= pub_word_r;
        end else if (!done_r) begin
            shift_r <= {shift_r[WORD_W-2:0], 1'b0};
        end
    end

    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            fall_cnt_r <= 6'h00;
            done_r <= 1'b0;
        end else begin
            if (!done_r) begin
                fall_cnt_r <= fall_cnt_r + 6'h01;
            end
            if (fall_cnt_r + 6'h01 == last_bit_cnt) begin
                done_r <= 1'b1;
            end
        end
    end

    // One toggle per frame at the last bit of the most significant data byte.
    // Its reset is asynchronous, so reset must rise while the serial clock is idle.
    always_ff @(negedge i_sclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            read_tgl_r <= 1'b0;
        // Read marked at MSB byte end.
        end else if (!done_r && fall_cnt_r + 6'h01 == msb_last_of(pub_hdr_r)) begin
            read_tgl_r <= ~read_tgl_r;
        end
    end

    // Without the dual function the last shifted bit stays on the pin.
    always_comb begin
        if (started_r && !done_r) begin
            o_dual_function_out_pin = shift_r[WORD_W-1];
        end else if (i_out_pin_function_sel) begin
            o_dual_function_out_pin = o_result_ready_n;
        end else begin
            o_dual_function_out_pin = shift_r[WORD_W-1];
        end
    end

    // The pin is released whenever the part is not selected.
    assign o_dual_function_out_pin_oe = ~i_cs_n;

endmodule : acr_readout

/* verification/acr_readout_monitor.sv */
// Port checker for the readout block: ready pin, status byte and pin muxing.
// Assumes it is bound into acr_readout; every check runs on the sample clock.
`timescale 1ns/10ps
module acr_readout_monitor (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_conv_start,
    input wire logic i_result_valid,
    input wire logic i_one_shot,
    input wire logic i_standby_after_conversion,
    input wire logic i_out_pin_function_sel,
    input wire logic [7:1] i_status_bits,
    input wire logic o_result_ready_n,
    input wire logic o_dual_function_out_pin,
    input wire logic o_dual_function_out_pin_oe,
    input wire logic [7:0] o_status_byte
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // Sampling the serial clock is coarse, but its high phase spans many sample cycles.
    logic sclk_seen_r;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_cs_n) begin
            sclk_seen_r <= 1'b0;
        end else if (i_sclk) begin
            sclk_seen_r <= 1'b1;
        end
    end
    ready_fall_a: assert property (
        i_result_valid && !i_conv_start && o_result_ready_n |=> !o_result_ready_n)
        else $error("ready did not fall after a result");
    start_high_a: assert property (i_conv_start |=> o_result_ready_n)
        else $error("ready not high after start");
    unread_pulse_a: assert property (
        i_result_valid && !i_conv_start && !o_result_ready_n ##1 !i_conv_start
        |-> o_result_ready_n ##1 !o_result_ready_n) else $error("no pulse before new result");
    stby_three_a: assert property (
        $fell(o_result_ready_n) && i_standby_after_conversion
        |-> !o_result_ready_n [*3] ##1 o_result_ready_n) else $error("standby ready timing");
    hdr_bits_a: assert property (o_status_byte[7:1] == i_status_bits)
        else $error("status byte upper bits");
    fresh_set_a: assert property (i_result_valid && !i_conv_start |=> o_status_byte[0])
        else $error("fresh bit not set");
    oe_follow_a: assert property (o_dual_function_out_pin_oe == !i_cs_n)
        else $error("pin enable does not follow select");
    mirror_ready_a: assert property (
        i_out_pin_function_sel && !i_cs_n && !sclk_seen_r && !i_sclk
        |-> o_dual_function_out_pin == o_result_ready_n) else $error("pin does not mirror");
    read_high_a: assert property (
        $fell(o_status_byte[0]) && !i_one_shot |-> ##[0:1] o_result_ready_n)
        else $error("ready not high after read");
    oneshot_low_a: assert property (
        $fell(o_status_byte[0]) && i_one_shot && !$past(i_conv_start) && !$past(i_conv_start, 2)
        |-> !o_result_ready_n) else $error("one-shot ready rose on read");
    cover property (i_result_valid && !o_result_ready_n);
    cover property ($fell(o_status_byte[0]) && i_one_shot);
    cover property ($fell(o_result_ready_n) && i_standby_after_conversion);
endmodule : acr_readout_monitor

bind acr_readout acr_readout_monitor acr_readout_monitor_i (.i_clk, .i_sys_rst, .i_sclk,
    .i_cs_n, .i_conv_start, .i_result_valid, .i_one_shot, .i_standby_after_conversion,
    .i_out_pin_function_sel, .i_status_bits, .o_result_ready_n, .o_dual_function_out_pin,
    .o_dual_function_out_pin_oe, .o_status_byte);

/* verification/acr_host_model.sv */
// Host serial master model: chip select and a 64 ns serial clock, sampling on falls.
// Assumes the block shifts on rises; the clock stands still low outside frames.
`timescale 1ns/10ps
module acr_host_model (
    input wire logic i_pin,
    output logic o_sclk,
    output logic o_cs_n
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b0;
        // A rising select at start clears the frame state of the block.
        #1;
        o_cs_n = 1'b1;
    end
    // No input line here, so the idle input bytes are not sent.
    // The bench reads results once each in frames timed by fixed delays; the last three results stay unread.
    task automatic select(input logic v);
        o_cs_n = v;
        #32.3;
    endtask : select
    task automatic shift(input int n, output logic [31:0] w);
        w = 32'h0000_0000;
        for (int k = 0; k < n; k++) begin
            o_sclk = 1'b1;
            #32;
            w = {w[30:0], i_pin};
            o_sclk = 1'b0;
            #32;
        end
    endtask : shift
endmodule : acr_host_model

/* verification/tb_acr_readout.sv */
// Self-checking bench for the readout block driven by the host serial model.
// Assumes a 250 MHz sample clock; the host clock is unrelated in phase.
`timescale 1ns/10ps
module tb_acr_readout;
    import acr_pkg::*;
    typedef struct packed {
        logic signed [RAW_W-1:0] raw;
        logic uni;
        logic ext;
        logic [DATA_W-1:0] code;
    } acr_row_t;
    localparam acr_row_t ROWS [17] = '{
        '{19'sh07fff, 1'b0, 1'b0, 16'h7fff}, '{19'sh09c40, 1'b0, 1'b0, 16'h7fff},
        '{19'sh00001, 1'b0, 1'b0, 16'h0001}, '{19'sh00000, 1'b0, 1'b0, 16'h0000},
        '{-19'sh00001, 1'b0, 1'b0, 16'hffff}, '{-19'sh08000, 1'b0, 1'b0, 16'h8000},
        '{-19'sh0c350, 1'b0, 1'b0, 16'h8000}, '{19'sh07fff, 1'b0, 1'b1, 16'h6666},
        '{-19'sh08000, 1'b0, 1'b1, 16'h999a}, '{19'sh0a000, 1'b0, 1'b1, 16'h7fff},
        '{-19'sh0a000, 1'b0, 1'b1, 16'h8000}, '{19'sh0ffff, 1'b1, 1'b0, 16'hffff},
        '{19'sh11170, 1'b1, 1'b0, 16'hffff}, '{-19'sh00005, 1'b1, 1'b0, 16'h0000},
        '{19'sh00001, 1'b1, 1'b0, 16'h0001}, '{19'sh0ffff, 1'b1, 1'b1, 16'hcccc},
        '{19'sh14000, 1'b1, 1'b1, 16'hffff}};
    logic i_clk = 1'b0;
    logic i_sys_rst;
    logic i_sclk;
    logic i_cs_n;
    logic i_conv_start;
    logic i_result_valid;
    logic signed [RAW_W-1:0] i_result_raw;
    logic i_unipolar;
    logic i_ext_range;
    logic i_one_shot;
    logic i_standby_after_conversion;
    logic i_out_pin_function_sel;
    logic i_status_hdr_en;
    logic i_crc_en;
    logic [7:1] i_status_bits;
    logic i_reg_read_pending;
    logic [7:0] i_reg_read_data;
    logic o_result_ready_n;
    logic o_dual_function_out_pin;
    logic o_dual_function_out_pin_oe;
    logic [7:0] o_status_byte;
    logic o_read_seen;
    logic [31:0] w;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    int reads_seen = 0;
    acr_readout acr_readout_i (.i_clk, .i_sys_rst, .i_sclk, .i_cs_n, .i_conv_start,
        .i_result_valid, .i_result_raw, .i_unipolar, .i_ext_range, .i_one_shot,
        .i_standby_after_conversion, .i_out_pin_function_sel, .i_status_hdr_en, .i_crc_en,
        .i_status_bits, .i_reg_read_pending, .i_reg_read_data, .o_result_ready_n,
        .o_dual_function_out_pin, .o_dual_function_out_pin_oe, .o_status_byte, .o_read_seen);
    acr_host_model acr_host_model_i (.i_pin(o_dual_function_out_pin), .o_sclk(i_sclk),
        .o_cs_n(i_cs_n));
    always #2 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles++;
        if (o_read_seen === 1'b1) begin
            reads_seen++;
        end
        if (cycles == 40000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (err_total == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task automatic chk_bit(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit
    task automatic result(input logic signed [RAW_W-1:0] r);
        i_result_raw = r;
        i_result_valid = 1'b1;
        tick(1);
        i_result_valid = 1'b0;
        tick(4);
    endtask : result
    task automatic frame(input int n);
        acr_host_model_i.select(1'b0);
        acr_host_model_i.shift(n, w);
        acr_host_model_i.select(1'b1);
        tick(2);
    endtask : frame
    // Check code shifted most significant bit first.
    function automatic logic [7:0] crc_of(input logic [23:0] b, input int nb);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 8 * nb - 1; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc_of
    task automatic frame_chk(input logic hdr, input logic crc);
        logic [31:0] e;
        int n;
        i_status_hdr_en = hdr;
        i_crc_en = crc;
        result(19'sh01234);
        n = 16 + 8 * int'(hdr) + 8 * int'(crc);
        e = hdr ? {8'h00, i_status_bits, 1'b1, 16'h1234} : 32'h0000_1234;
        if (crc) begin
            e = {e[23:0], crc_of(e[23:0], 2 + int'(hdr))};
        end
        acr_host_model_i.select(1'b0);
        chk_bit("pin before clock", 1'b0, o_dual_function_out_pin);
        acr_host_model_i.shift(n, w);
        chk_bit("pin after frame", 1'b1, o_dual_function_out_pin);
        acr_host_model_i.select(1'b1);
        tick(2);
        chk_word("frame", e, w);
        chk_bit("fresh after read", 1'b0, o_status_byte[0]);
        chk_bit("ready after read", 1'b1, o_result_ready_n);
    endtask : frame_chk
    initial begin
        i_sys_rst = 1'b0;
        i_conv_start = 1'b0;
        i_result_valid = 1'b0;
        i_result_raw = 19'sh00000;
        i_unipolar = 1'b0;
        i_ext_range = 1'b0;
        i_one_shot = 1'b0;
        i_standby_after_conversion = 1'b0;
        i_out_pin_function_sel = 1'b1;
        i_status_hdr_en = 1'b0;
        i_crc_en = 1'b0;
        i_status_bits = 7'h55;
        i_reg_read_pending = 1'b0;
        i_reg_read_data = 8'ha5;
        // Reset rises after time zero so that the serial side sees its edge.
        #1;
        i_sys_rst = 1'b1;
        tick(12);
        i_sys_rst = 1'b0;
        tick(2);
        for (int k = 0; k < 17; k++) begin
            i_unipolar = ROWS[k].uni;
            i_ext_range = ROWS[k].ext;
            result(ROWS[k].raw);
            chk_bit("ready low", 1'b0, o_result_ready_n);
            frame(16);
            chk_word("code", {16'h0000, ROWS[k].code}, w);
        end
        i_unipolar = 1'b0;
        i_ext_range = 1'b0;
        frame_chk(1'b1, 1'b1);
        i_status_bits = 7'h2a;
        frame_chk(1'b1, 1'b0);
        frame_chk(1'b0, 1'b1);
        i_status_hdr_en = 1'b1;
        i_crc_en = 1'b1;
        result(19'sh01234);
        frame(16);
        chk_word("short stop", {16'h0000, i_status_bits, 1'b1, 8'h12}, w);
        chk_bit("ready after stop", 1'b1, o_result_ready_n);
        chk_bit("fresh after stop", 1'b0, o_status_byte[0]);
        i_status_hdr_en = 1'b0;
        i_crc_en = 1'b0;
        i_reg_read_pending = 1'b1;
        i_reg_read_data = 8'h3c;
        result(19'sh00777);
        frame(16);
        chk_word("readback", 32'h0000_3c00, w);
        i_reg_read_pending = 1'b0;
        result(19'sh00111);
        acr_host_model_i.select(1'b0);
        fork
            acr_host_model_i.shift(16, w);
            begin
                tick(10);
                result(19'sh00222);
            end
        join
        acr_host_model_i.select(1'b1);
        tick(2);
        chk_word("old data", 32'h0000_0111, w);
        chk_bit("fresh kept", 1'b1, o_status_byte[0]);
        frame(16);
        chk_word("new data", 32'h0000_0222, w);
        i_out_pin_function_sel = 1'b0;
        result(19'sh00003);
        frame(16);
        result(19'sh00002);
        acr_host_model_i.select(1'b0);
        chk_bit("held level", 1'b1, o_dual_function_out_pin);
        acr_host_model_i.shift(16, w);
        acr_host_model_i.select(1'b1);
        chk_word("after hold", 32'h0000_0002, w);
        i_out_pin_function_sel = 1'b1;
        i_one_shot = 1'b1;
        result(19'sh00005);
        frame(16);
        chk_bit("one-shot ready", 1'b0, o_result_ready_n);
        i_conv_start = 1'b1;
        tick(1);
        i_conv_start = 1'b0;
        tick(1);
        chk_bit("start ready", 1'b1, o_result_ready_n);
        i_one_shot = 1'b0;
        i_standby_after_conversion = 1'b1;
        i_result_valid = 1'b1;
        tick(1);
        i_result_valid = 1'b0;
        tick(1);
        chk_bit("standby low", 1'b0, o_result_ready_n);
        tick(3);
        chk_bit("standby high", 1'b1, o_result_ready_n);
        i_standby_after_conversion = 1'b0;
        result(19'sh00007);
        result(19'sh00008);
        chk_bit("ready second", 1'b0, o_result_ready_n);
        i_sys_rst = 1'b1;
        tick(3);
        chk_bit("reset ready", 1'b1, o_result_ready_n);
        chk_bit("reset fresh", 1'b0, o_status_byte[0]);
        i_sys_rst = 1'b0;
        tick(2);
        chk_word("reads", 32'h0000_001b, reads_seen);
        complete_run();
    end
endmodule : tb_acr_readout
